//--- pkg/aon_wake_pkg.sv
package aon_wake_pkg;
  // core and slow clock rates
  localparam int unsigned CORE_CLK_HZ = 100000000;
  localparam int unsigned SLOW_CLK_HZ = 32000;
  localparam int unsigned SLOW_DIV_CYCLES = CORE_CLK_HZ / SLOW_CLK_HZ;
  // special function register addresses
  localparam logic [7:0] SFR_DATA_HIGH = 8'hAB;
  localparam logic [7:0] SFR_DATA_LOW = 8'hAC;
  localparam logic [7:0] SFR_CONTROL = 8'hAD;
  localparam logic [7:0] SFR_TICK_DIV = 8'hB5;
  // reset values
  localparam logic [7:0] DATA_HIGH_RST = 8'h00;
  localparam logic [7:0] DATA_LOW_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] TICK_DIV_RST = 8'h03;
  // control register fields
  localparam int unsigned CTRL_BUSY_BIT = 4;
  localparam int unsigned CTRL_WRITE_BIT = 3;
  localparam int unsigned CTRL_ADDR_LSB = 0;
  // indirect addresses
  localparam logic [2:0] IA_WATCHDOG = 3'h0;
  localparam logic [2:0] IA_TIMER_UPPER = 3'h1;
  localparam logic [2:0] IA_LATCH_LOW = 3'h2;
  localparam logic [2:0] IA_COUNT_DIS = 3'h3;
  localparam logic [2:0] IA_PIN_CFG_A = 3'h4;
  localparam logic [2:0] IA_PIN_CFG_B = 3'h5;
  // status word layout
  localparam int unsigned STAT_TIMER_BIT = 8;
  // debounce lengths in slow clock pulses
  localparam logic [6:0] DEB_LEN_0 = 7'h00;
  localparam logic [6:0] DEB_LEN_1 = 7'h02;
  localparam logic [6:0] DEB_LEN_2 = 7'h08;
  localparam logic [6:0] DEB_LEN_3 = 7'h40;
  // edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [3:0] PIN_CFG_RST = 4'h0;

  // one pin's wake field: edge in upper pair, debounce in lower
  typedef struct packed {
    logic [1:0] edge_sel;
    logic [1:0] deb_sel;
  } pin_cfg_t;

  // pending indirect access
  typedef struct packed {
    logic write;
    logic [2:0] addr;
  } ind_ctrl_t;

  // sfr bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage : aon_wake_pkg

//--- src/always_on_wakeup_watchdog.sv
// Contract
// - timer, pin wake and watchdog run on a 32000 Hz slow clock
// - tick period is divider plus one slow periods, divider resets to 3
// - tick spans 31.25 us to 8 ms and paces watchdog and timer
// - wake timer is a 24-bit down counter reloading from its latch at zero
// - timer starts off; each low latch write enables it and reloads it
// - write at address 3 disables the timer; read returns the count
// - first wake N+1 to N+2 ticks after load, then every N+1
// - timer wake sets a pollable flag and forces exit from power down
// - each pin has 2-bit edge select: off, rising, falling, both
// - debounce passes a level after 0, 2, 8 or 64 stable pulses
// - edge detection adds two slow clock pulses of latency
// - watchdog starts on first control write; only reset stops it
// - watchdog loads a 16-bit tick count, counts down, resets MCU at zero
// - write: high, low, control; read: control, then high, then low
// - control bit 4 busy, bit 3 write, bits 2:0 indirect address
// - address 0 is watchdog count, address 2 the low latch half
// - address 1 reads count and latch upper bytes, writes filter timer and latch upper byte
// - addresses 4 and 5 read timer status bit 8 and pin status
// - address 4 configures pins 0-3, address 5 pins 4-5
`timescale 1ns/1ps
module always_on_wakeup_watchdog
  import aon_wake_pkg::*;
#(
  parameter int unsigned NUM_PINS = 6,
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire aon_wake_pkg::sfr_req_t sfr_req_i,
  input wire logic [NUM_PINS-1:0] port0_pin_i,
  input wire logic power_down_i,
  output logic [7:0] sfr_rdata_o,
  output logic wakeup_interrupt_o,
  output logic power_down_exit_o,
  output logic timer_wake_flag_o,
  output logic mcu_reset_o
);
  import aon_wake_pkg::*;

  logic slow_en;
  logic tick_en;
  logic [NUM_PINS-1:0] pin_edge;

  // sfr side registers
  logic [7:0] indirect_data_high_r;
  logic [7:0] indirect_data_low_r;
  logic [7:0] tick_divider_reg_r;
  ind_ctrl_t ctrl_r;
  logic busy_r;

  // slow side state
  logic [15:0] watchdog_cnt_r;
  logic watchdog_active_r;
  logic [23:0] timer_cnt_r;
  logic [7:0] latch_high_r;
  logic [15:0] timer_latch_low_r;
  logic timer_en_r;
  logic timer_skip_r;
  logic [3:0] filter_timer_latch_r;
  pin_cfg_t [NUM_PINS-1:0] pin_cfg_r;
  logic [NUM_PINS-1:0] pin_status_r;
  logic timer_status_r;

  // combinational helpers
  logic do_access;
  logic do_write;
  logic do_read;
  logic status_read;
  logic timer_fire;
  logic [15:0] wdata;
  logic [15:0] status_word;
  logic [15:0] read_word;

  slow_tick_gen #(
    .DIV_CYCLES(SLOW_DIV)
  ) u_tick (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_divider_value_i(tick_divider_reg_r),
    .slow_clock_en_o(slow_en),
    .tick_en_o(tick_en)
  );

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pin_wake_filter u_filt (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .slow_clock_en_i(slow_en),
      .pin_i(port0_pin_i[p]),
      .cfg_i(pin_cfg_r[p]),
      .edge_o(pin_edge[p])
    );
  end

  // pending access executes on the next slow clock pulse
  assign do_access = busy_r & slow_en;
  assign do_write = do_access & ctrl_r.write;
  assign do_read = do_access & ~ctrl_r.write;
  assign wdata = {indirect_data_high_r, indirect_data_low_r};
  assign status_read = do_read && (ctrl_r.addr == IA_PIN_CFG_A || ctrl_r.addr == IA_PIN_CFG_B);
  assign timer_fire = tick_en & timer_en_r & ~timer_skip_r & (timer_cnt_r == 24'h000000);

  // status word shared by both status addresses
  always_comb begin
    status_word = 16'h0000;
    status_word[STAT_TIMER_BIT] = timer_status_r;
    status_word[NUM_PINS-1:0] = pin_status_r;
  end

  // indirect read mux
  always_comb begin
    case (ctrl_r.addr)
      IA_WATCHDOG: read_word = watchdog_cnt_r;
      IA_TIMER_UPPER: read_word = {timer_cnt_r[23:16], latch_high_r};
      IA_LATCH_LOW: read_word = timer_latch_low_r;
      IA_COUNT_DIS: read_word = timer_cnt_r[15:0];
      IA_PIN_CFG_A: read_word = status_word;
      IA_PIN_CFG_B: read_word = status_word;
      default: read_word = 16'h0000;
    endcase
  end

  // data pair: written by the core, loaded by indirect reads
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      indirect_data_high_r <= DATA_HIGH_RST;
      indirect_data_low_r <= DATA_LOW_RST;
    end else if (do_read) begin
      indirect_data_high_r <= read_word[15:8];
      indirect_data_low_r <= read_word[7:0];
    end else if (sfr_req_i.wr) begin
      if (sfr_req_i.addr == SFR_DATA_HIGH) begin
        indirect_data_high_r <= sfr_req_i.wdata;
      end
      if (sfr_req_i.addr == SFR_DATA_LOW) begin
        indirect_data_low_r <= sfr_req_i.wdata;
      end
    end
  end

  // control register and busy flag; a new write restarts the access
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= ind_ctrl_t'(CONTROL_RST[3:0]);
      busy_r <= 1'b0;
    end else if (sfr_req_i.wr && sfr_req_i.addr == SFR_CONTROL) begin
      ctrl_r.write <= sfr_req_i.wdata[CTRL_WRITE_BIT];
      ctrl_r.addr <= sfr_req_i.wdata[CTRL_ADDR_LSB +: 3];
      busy_r <= 1'b1;
    end else if (do_access) begin
      busy_r <= 1'b0;
    end
  end

  // tick divider
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_divider_reg_r <= TICK_DIV_RST;
    end else if (sfr_req_i.wr && sfr_req_i.addr == SFR_TICK_DIV) begin
      tick_divider_reg_r <= sfr_req_i.wdata;
    end
  end

  // registered read port, answer one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_req_i.rd) begin
      case (sfr_req_i.addr)
        SFR_DATA_HIGH: sfr_rdata_o <= indirect_data_high_r;
        SFR_DATA_LOW: sfr_rdata_o <= indirect_data_low_r;
        SFR_CONTROL: sfr_rdata_o <= {3'h0, busy_r, ctrl_r};
        SFR_TICK_DIV: sfr_rdata_o <= tick_divider_reg_r;
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // watchdog: armed by any control write, counts ticks to zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_active_r <= 1'b0;
      watchdog_cnt_r <= 16'h0000;
    end else begin
      if (sfr_req_i.wr && sfr_req_i.addr == SFR_CONTROL) begin
        watchdog_active_r <= 1'b1;
      end
      if (do_write && ctrl_r.addr == IA_WATCHDOG) begin
        watchdog_cnt_r <= wdata;
      end else if (watchdog_active_r && tick_en && watchdog_cnt_r != 16'h0000) begin
        watchdog_cnt_r <= watchdog_cnt_r - 16'h0001;
      end
    end
  end

  // reset request held while armed, expired and no access is pending; a control write or the system reset clears it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mcu_reset_o <= 1'b0;
    end else begin
      mcu_reset_o <= watchdog_active_r & (watchdog_cnt_r == 16'h0000) & ~busy_r;
    end
  end

  // latch halves and filter timer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_high_r <= 8'h00;
      timer_latch_low_r <= 16'h0000;
      filter_timer_latch_r <= 4'h0;
    end else if (do_write) begin
      if (ctrl_r.addr == IA_TIMER_UPPER) begin
        filter_timer_latch_r <= wdata[11:8];
        latch_high_r <= wdata[7:0];
      end
      if (ctrl_r.addr == IA_LATCH_LOW) begin
        timer_latch_low_r <= wdata;
      end
    end
  end

  // wake timer: low latch write enables and reloads, disable opcode stops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_en_r <= 1'b0;
      timer_skip_r <= 1'b0;
      timer_cnt_r <= 24'h000000;
    end else if (do_write && ctrl_r.addr == IA_LATCH_LOW) begin
      timer_en_r <= 1'b1;
      timer_skip_r <= 1'b1;
      timer_cnt_r <= {latch_high_r, wdata};
    end else if (do_write && ctrl_r.addr == IA_COUNT_DIS) begin
      timer_en_r <= 1'b0;
    end else if (tick_en && timer_skip_r) begin
      // load lands mid tick; swallowing the first tick keeps the first wake late, never early
      timer_skip_r <= 1'b0;
    end else if (timer_fire) begin
      timer_cnt_r <= {latch_high_r, timer_latch_low_r};
    end else if (tick_en && timer_en_r) begin
      timer_cnt_r <= timer_cnt_r - 24'h000001;
    end
  end

  // pin configuration fields
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_cfg_r <= '0;
    end else if (do_write && ctrl_r.addr == IA_PIN_CFG_A) begin
      // separate loops keep every slice inside the data word
      for (int p = 0; p < 4; p++) begin
        pin_cfg_r[p] <= wdata[p*4 +: 4];
      end
    end else if (do_write && ctrl_r.addr == IA_PIN_CFG_B) begin
      for (int p = 4; p < NUM_PINS; p++) begin
        pin_cfg_r[p] <= wdata[(p-4)*4 +: 4];
      end
    end
  end

  // sticky wake flags cleared by a status read; a new event wins
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_status_r <= 1'b0;
      pin_status_r <= '0;
    end else begin
      timer_status_r <= timer_fire | (timer_status_r & ~status_read);
      pin_status_r <= pin_edge | (pin_status_r & {NUM_PINS{~status_read}});
    end
  end

  // wake outputs; power down exit ignores any interrupt enable
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wakeup_interrupt_o <= 1'b0;
      power_down_exit_o <= 1'b0;
      timer_wake_flag_o <= 1'b0;
    end else begin
      wakeup_interrupt_o <= timer_fire | (|pin_edge);
      power_down_exit_o <= power_down_i & (timer_fire | (|pin_edge));
      timer_wake_flag_o <= timer_fire | (timer_status_r & ~status_read);
    end
  end
endmodule : always_on_wakeup_watchdog

//--- src/pin_wake_filter.sv
`timescale 1ns/1ps
module pin_wake_filter
  import aon_wake_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic slow_clock_en_i,
  input wire logic pin_i,
  input wire aon_wake_pkg::pin_cfg_t cfg_i,
  output logic edge_o
);
  import aon_wake_pkg::*;

  logic [6:0] stable_cnt_r;
  logic filt_r;
  logic dly1_r;
  logic dly2_r;
  logic [6:0] deb_len;

  function automatic logic [6:0] deb_decode(input logic [1:0] code);
    case (code)
      2'h1: deb_decode = DEB_LEN_1;
      2'h2: deb_decode = DEB_LEN_2;
      2'h3: deb_decode = DEB_LEN_3;
      default: deb_decode = DEB_LEN_0;
    endcase
  endfunction : deb_decode

  assign deb_len = deb_decode(cfg_i.deb_sel);

  // pass a new level only after it held for the selected count
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_cnt_r <= 7'h00;
      filt_r <= 1'b0;
    end else if (slow_clock_en_i) begin
      if (pin_i == filt_r) begin
        stable_cnt_r <= 7'h00;
      end else if (stable_cnt_r + 7'h01 >= deb_len) begin
        filt_r <= pin_i;
        stable_cnt_r <= 7'h00;
      end else begin
        stable_cnt_r <= stable_cnt_r + 7'h01;
      end
    end
  end

  // two slow stages before the edge compare
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly1_r <= 1'b0;
      dly2_r <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      if (slow_clock_en_i) begin
        dly1_r <= filt_r;
        dly2_r <= dly1_r;
      end
      case (cfg_i.edge_sel)
        EDGE_RISE: edge_o <= slow_clock_en_i & dly1_r & ~dly2_r;
        EDGE_FALL: edge_o <= slow_clock_en_i & ~dly1_r & dly2_r;
        EDGE_BOTH: edge_o <= slow_clock_en_i & (dly1_r ^ dly2_r);
        default: edge_o <= 1'b0;
      endcase
    end
  end
endmodule : pin_wake_filter

//--- src/slow_tick_gen.sv
`timescale 1ns/1ps
module slow_tick_gen
  import aon_wake_pkg::*;
#(
  parameter int unsigned DIV_CYCLES = SLOW_DIV_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] tick_divider_value_i,
  output logic slow_clock_en_o,
  output logic tick_en_o
);
  import aon_wake_pkg::*;

  logic [11:0] slow_cnt_r;
  logic [7:0] tick_cnt_r;

  // slow clock as an enable; one clock domain keeps crossings away
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_cnt_r <= 12'h000;
      slow_clock_en_o <= 1'b0;
    end else if (slow_cnt_r == 12'(DIV_CYCLES - 1)) begin
      slow_cnt_r <= 12'h000;
      slow_clock_en_o <= 1'b1;
    end else begin
      slow_cnt_r <= slow_cnt_r + 12'h001;
      slow_clock_en_o <= 1'b0;
    end
  end

  // tick every divider+1 slow periods
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= 8'h00;
      tick_en_o <= 1'b0;
    end else if (slow_clock_en_o && tick_cnt_r >= tick_divider_value_i) begin
      tick_cnt_r <= 8'h00;
      tick_en_o <= 1'b1;
    end else begin
      if (slow_clock_en_o) begin
        tick_cnt_r <= tick_cnt_r + 8'h01;
      end
      tick_en_o <= 1'b0;
    end
  end
endmodule : slow_tick_gen

//--- tb/aon_wake_asserts.sv
`timescale 1ns/1ps
module aon_wake_asserts
  import aon_wake_pkg::*;
#(
  parameter int unsigned NUM_PINS = 6
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire aon_wake_pkg::sfr_req_t sfr_req_i,
  input wire logic [NUM_PINS-1:0] port0_pin_i,
  input wire logic power_down_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic wakeup_interrupt_o,
  input wire logic power_down_exit_o,
  input wire logic timer_wake_flag_o,
  input wire logic mcu_reset_o
);
  logic [7:0] div_r;
  logic [3:0] ctrl_r;
  logic ctrl_wr;
  logic mapped;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // decode of the bus request, kept out of the properties
  assign ctrl_wr = sfr_req_i.wr && sfr_req_i.addr == SFR_CONTROL;
  assign mapped = sfr_req_i.addr inside {SFR_DATA_HIGH, SFR_DATA_LOW, SFR_CONTROL, SFR_TICK_DIV};
  // shadow of the divider, to catch a stuck or mis-decoded register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= TICK_DIV_RST;
    end else if (sfr_req_i.wr && sfr_req_i.addr == SFR_TICK_DIV) begin
      div_r <= sfr_req_i.wdata;
    end
  end
  // shadow of the writable control bits
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CONTROL_RST[3:0];
    end else if (ctrl_wr) begin
      ctrl_r <= sfr_req_i.wdata[3:0];
    end
  end
  property p_div_rd;
    sfr_req_i.rd && sfr_req_i.addr == SFR_TICK_DIV |=> sfr_rdata_o == div_r;
  endproperty
  a_div_rd: assert property (p_div_rd)
    else $error("divider read wrong");
  property p_ctrl_rd;
    sfr_req_i.rd && sfr_req_i.addr == SFR_CONTROL |=> sfr_rdata_o[7:5] == 3'h0 && sfr_rdata_o[3:0] == ctrl_r;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control read wrong");
  property p_busy;
    ctrl_wr ##1 (sfr_req_i.rd && sfr_req_i.addr == SFR_CONTROL) |=> sfr_rdata_o[CTRL_BUSY_BIT];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not shown");
  property p_unmapped;
    sfr_req_i.rd && !mapped |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdata_hold;
    $changed(sfr_rdata_o) |-> $past(sfr_req_i.rd);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  property p_pdx;
    power_down_exit_o |-> wakeup_interrupt_o && $past(power_down_i);
  endproperty
  a_pdx: assert property (p_pdx)
    else $error("power down exit without cause");
  property p_pulse;
    wakeup_interrupt_o |=> !wakeup_interrupt_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("wake pulse too long");
  property p_flag;
    $rose(timer_wake_flag_o) |-> wakeup_interrupt_o || $past(wakeup_interrupt_o);
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag set without wake");
  property p_wd_fall;
    $fell(mcu_reset_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
  endproperty
  a_wd_fall: assert property (p_wd_fall)
    else $error("watchdog reset dropped alone");
endmodule : aon_wake_asserts

bind always_on_wakeup_watchdog aon_wake_asserts #(.NUM_PINS(NUM_PINS)) u_aon_wake_asserts (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i), .port0_pin_i(port0_pin_i),
  .power_down_i(power_down_i), .sfr_rdata_o(sfr_rdata_o), .wakeup_interrupt_o(wakeup_interrupt_o),
  .power_down_exit_o(power_down_exit_o), .timer_wake_flag_o(timer_wake_flag_o), .mcu_reset_o(mcu_reset_o));

//--- tb/sfr_master.sv
`timescale 1ns/1ps
module sfr_master
  import aon_wake_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [7:0] sfr_rdata_i,
  output aon_wake_pkg::sfr_req_t sfr_req_o
);
  int n_timeouts;
  // bus idle from time zero
  initial begin
    sfr_req_o = '0;
    n_timeouts = 0;
  end
  // one strobe, taken at the next edge; caller enters just after an edge
  task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    sfr_req_o = '{w, r, a, d};
    @(posedge core_clk_i);
    #1;
  endtask : put
  task automatic idle();
    sfr_req_o = '0;
    @(posedge core_clk_i);
    #1;
  endtask : idle
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    put(1'h0, 1'h1, a, 8'h00);
    d = sfr_rdata_i;
  endtask : rd8
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    put(1'h1, 1'h0, a, d);
    idle();
  endtask : wr8
  // slow side finishes later, so poll busy before moving on
  task automatic wait_idle();
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 0; i < 64 && c[CTRL_BUSY_BIT]; i++) begin
      rd8(SFR_CONTROL, c);
    end
    if (c[CTRL_BUSY_BIT]) n_timeouts++;
  endtask : wait_idle
  // callers use indirect addresses 0 to 5 only
  task automatic iwr(input logic [2:0] ia, input logic [15:0] d);
    put(1'h1, 1'h0, SFR_DATA_HIGH, d[15:8]);
    put(1'h1, 1'h0, SFR_DATA_LOW, d[7:0]);
    put(1'h1, 1'h0, SFR_CONTROL, {4'h1, 1'h1, ia} & 8'h0F);
    wait_idle();
    idle();
  endtask : iwr
  task automatic ird(input logic [2:0] ia, output logic [15:0] d);
    put(1'h1, 1'h0, SFR_CONTROL, {5'h00, ia});
    wait_idle();
    rd8(SFR_DATA_HIGH, d[15:8]);
    rd8(SFR_DATA_LOW, d[7:0]);
    idle();
  endtask : ird
endmodule : sfr_master

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import aon_wake_pkg::*;
  typedef struct {logic ind; logic [7:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_t;
  logic core_clk_i, rst_n_i, power_down_i;
  logic [5:0] port0_pin_i;
  sfr_req_t sfr_req_i;
  logic [7:0] sfr_rdata_o;
  logic wakeup_interrupt_o, power_down_exit_o, timer_wake_flag_o, mcu_reset_o;
  int n_errors, compares, n, px, t;
  logic [15:0] d16;
  // divider 1 and latch 3 give a 32-cycle timer period with the short slow clock
  row_t rows [5] = '{'{1'h0, SFR_TICK_DIV, 16'h0001, 16'h0001}, '{1'h0, SFR_DATA_HIGH, 16'h005A, 16'h005A},
    '{1'h0, 8'hC3, 16'h0012, 16'h0000}, '{1'h1, 8'h01, 16'h0300, 16'h0000}, '{1'h1, 8'h02, 16'h0003, 16'h0003}};
  logic [7:0] rst_addr [4] = '{SFR_DATA_HIGH, SFR_DATA_LOW, SFR_CONTROL, SFR_TICK_DIV};
  logic [7:0] rst_val [4] = '{DATA_HIGH_RST, DATA_LOW_RST, CONTROL_RST, TICK_DIV_RST};

  always_on_wakeup_watchdog #(.SLOW_DIV(4)) u_always_on_wakeup_watchdog (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .sfr_req_i(sfr_req_i), .port0_pin_i(port0_pin_i), .power_down_i(power_down_i),
    .sfr_rdata_o(sfr_rdata_o), .wakeup_interrupt_o(wakeup_interrupt_o), .power_down_exit_o(power_down_exit_o),
    .timer_wake_flag_o(timer_wake_flag_o), .mcu_reset_o(mcu_reset_o));
  sfr_master u_sfr_master (.core_clk_i(core_clk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_req_o(sfr_req_i));

  initial begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    n_errors += u_sfr_master.n_timeouts;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // count wake and power down exit pulses over a window
  task automatic count_wake(input int cycles);
    n = 0;
    px = 0;
    repeat (cycles) begin
      @(posedge core_clk_i);
      #1;
      if (wakeup_interrupt_o === 1'h1) n++;
      if (power_down_exit_o === 1'h1) px++;
    end
  endtask : count_wake
  task automatic wait_wake(input int bound);
    t = 0;
    while (wakeup_interrupt_o !== 1'h1 && t < bound) begin
      @(posedge core_clk_i);
      #1;
      t++;
    end
    if (t >= bound) begin
      n_errors++;
      complete_run();
    end
  endtask : wait_wake
  task automatic do_reset();
    rst_n_i = 1'h0;
    repeat (8) @(posedge core_clk_i);
    #1;
    rst_n_i = 1'h1;
  endtask : do_reset
  // hang guard
  initial begin
    #300000;
    n_errors++;
    complete_run();
  end
  initial begin
    n_errors = 0;
    compares = 0;
    power_down_i = 1'h0;
    port0_pin_i = 6'h00;
    do_reset();
    u_sfr_master.iwr(IA_WATCHDOG, 16'hFFFF); // long count keeps the watchdog quiet
    foreach (rows[i]) begin
      d16 = 16'h0000;
      if (rows[i].ind) begin
        u_sfr_master.iwr(rows[i].addr[2:0], rows[i].wdata);
        u_sfr_master.ird(rows[i].addr[2:0], d16);
      end else begin
        u_sfr_master.wr8(rows[i].addr, rows[i].wdata[7:0]);
        u_sfr_master.rd8(rows[i].addr, d16[7:0]);
        u_sfr_master.idle();
      end
      check(d16, rows[i].exp);
    end
    // period: one step plus the wait equals (N+1) ticks of 8 cycles
    wait_wake(200);
    count_wake(1);
    wait_wake(100);
    check(16'(t), 16'h001F);
    check({15'h0, timer_wake_flag_o}, 16'h0001);
    power_down_i = 1'h1;
    count_wake(40);
    check(16'(px), 16'h0001);
    power_down_i = 1'h0;
    u_sfr_master.iwr(IA_COUNT_DIS, 16'h0000);
    count_wake(100);
    check(16'(n), 16'h0000);
    u_sfr_master.iwr(IA_LATCH_LOW, 16'h0003);
    wait_wake(100);
    check({15'h0, t >= 29 && t <= 40}, 16'h0001);
    u_sfr_master.iwr(IA_COUNT_DIS, 16'h0000);
    u_sfr_master.ird(IA_PIN_CFG_A, d16);
    check(d16, 16'h0100);
    // every edge code on pin 0, no debounce
    for (int e = 0; e < 4; e++) begin
      u_sfr_master.iwr(IA_PIN_CFG_A, 16'(e * 4));
      port0_pin_i[0] = 1'h1;
      count_wake(40);
      check(16'(n), 16'(e % 2));
      port0_pin_i[0] = 1'h0;
      count_wake(40);
      check(16'(n), 16'(e / 2));
    end
    // rising edge, 8-pulse filter: a short glitch is swallowed
    u_sfr_master.iwr(IA_PIN_CFG_A, 16'h0006);
    port0_pin_i[0] = 1'h1;
    count_wake(20);
    port0_pin_i[0] = 1'h0;
    count_wake(60);
    check(16'(n), 16'h0000);
    port0_pin_i[0] = 1'h1;
    count_wake(28);
    check(16'(n), 16'h0000);
    count_wake(40);
    check(16'(n), 16'h0001);
    u_sfr_master.iwr(IA_PIN_CFG_B, 16'h0040);
    port0_pin_i[5] = 1'h1;
    count_wake(40);
    check(16'(n), 16'h0001);
    u_sfr_master.ird(IA_PIN_CFG_B, d16);
    check(d16, 16'h0021);
    // falling edge, 64-pulse filter on pin 5: one pulse short stays quiet
    u_sfr_master.iwr(IA_PIN_CFG_B, 16'h00B0);
    port0_pin_i[5] = 1'h0;
    count_wake(252);
    check(16'(n), 16'h0000);
    count_wake(40);
    check(16'(n), 16'h0001);
    // short watchdog count expires, reload clears it
    u_sfr_master.iwr(IA_WATCHDOG, 16'h0004);
    u_sfr_master.ird(IA_WATCHDOG, d16);
    check({15'h0, d16 >= 16'h0002 && d16 <= 16'h0004}, 16'h0001);
    count_wake(60);
    check({15'h0, mcu_reset_o}, 16'h0001);
    u_sfr_master.iwr(IA_WATCHDOG, 16'h0100);
    check({15'h0, mcu_reset_o}, 16'h0000);
    do_reset();
    foreach (rst_addr[i]) begin
      u_sfr_master.rd8(rst_addr[i], d16[7:0]);
      u_sfr_master.idle();
      check({8'h00, d16[7:0]}, {8'h00, rst_val[i]});
    end
    port0_pin_i = 6'h00;
    count_wake(100);
    check({14'h0, mcu_reset_o, 16'(n) != 16'h0}, 16'h0000);
    complete_run();
  end
endmodule : tb_top
